// >>> rtl/sws_defines.svh
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH

// Clock rate and printed times
`define SWS_CLK_HZ            125000000.0
`define SWS_SAMPLE_PERIOD_MS  62.5
`define SWS_TIME_CLK_KHZ      8.192
// Least time rounds up, rate period rounds down
`define SWS_SAMPLE_CYC        $rtoi($ceil(`SWS_SAMPLE_PERIOD_MS * `SWS_CLK_HZ / 1000.0))
`define SWS_TICK_CYC          $rtoi(`SWS_CLK_HZ / (`SWS_TIME_CLK_KHZ * 1000.0))
`define SWS_IRQ_PULSE_CYC     8'h08

// Register byte offsets
`define SWS_ADDR_CTRL         8'h00
`define SWS_ADDR_STATUS       8'h04
`define SWS_ADDR_MASK         8'h08
`define SWS_ADDR_TIME         8'h0c
`define SWS_ADDR_STAMP2       8'h10

// Field positions
`define SWS_CTRL_WIDTH        14
`define SWS_STS_FLAG_BIT      0
`define SWS_STS_STOP_BIT      1
`define SWS_STS_VALID_BIT     2
`define SWS_STS_LEVEL_BIT     3

// Field encodings and reset values
`define SWS_PIN_MODE_INPUT    2'h3
`define SWS_STAMP2_LAST_EVENT 3'h5
`define SWS_IRQ_A_PIN_IRQ     2'h2
`define SWS_CTRL_RESET        14'h0000
`define SWS_MASK_RESET        1'h0

`endif

// >>> rtl/sws_pkg.sv
package sws_pkg;

  typedef struct packed {
    logic [1:0] irq_a_pin_mode;
    logic       unused_gap;
    logic [2:0] second_stamp_mode;
    logic       irq_a_level_not_pulse;
    logic       stamp_irq_enable_a;
    logic       pin_stop_mode;
    logic       stamp_polarity_low;
    logic       stamp_input_switch_select;
    logic       zero_gap;
    logic [1:0] stamp_pin_mode;
  } sws_cfg_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } sws_wb_req_t;

  typedef struct packed {
    sws_cfg_t    cfg;
    logic        mask;
    logic        flag;
    logic [31:0] time_cnt;
    logic [31:0] stamp2;
    logic        sync1;
    logic        sync2;
    logic        samp_valid;
    logic        samp_lvl;
    logic        stop;
    logic [7:0]  pulse_cnt;
    logic        ack;
    logic [31:0] dat;
  } sws_state_t;

endpackage

// >>> rtl/sws_rate_div.sv
`timescale 1ns/1ps
module sws_rate_div #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      tick_o
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_nxt;

  // Restarts on enable so the first tick is one full period later
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!en_i) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r >= 32'(DIV - 1)) begin
      cnt_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule

// >>> rtl/sws_stamp_ctrl.sv
// Summary of operation
// - The sampler output is invalid until switch detection is on, and with the switch select bit set a full sample period passes before it shows the pin.
// - Stamp pin mode 11 makes the stamp pin an input; other codes leave it unused here.
// - With the switch select bit set the pin is sampled periodically instead of every cycle.
// - With the polarity bit set a low pin level is the active state.
// - With pin stop mode set the sampled level drives the internal stop signal.
// - The stamp interrupt enable lets stamp loads raise interrupt output A.
// - Second stamp mode 101 loads the second stamp register on every event, keeping the latest.
// - Interrupt A pin mode 10 drives interrupt output A with interrupt signalling.
// - A pin change causes nothing until a sample has caught it.
// - With active low polarity, a high sample followed by a low sample raises an event.
// - With pin stop and active low polarity, counting halts while the sampled level is low.
// - In second stamp mode 101 an event copies the current time into the second stamp register and sets its flag.
// - With pulse mode and interrupts enabled each stamp load gives a pulse on output A.
// - A sample back at the inactive high level releases stop and counting resumes.
// - While stop is asserted the 8.192 kHz tick does not advance the time.
`timescale 1ns/1ps
`include "sws_defines.svh"
module sws_stamp_ctrl #(
  parameter int unsigned SAMPLE_DIV = `SWS_SAMPLE_CYC,
  parameter int unsigned TICK_DIV   = `SWS_TICK_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire sws_pkg::sws_wb_req_t wb_req_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  input  wire logic                 stamp_pin_i,
  output logic                      irq_out_a_o,
  output logic                      irq_o,
  output logic                      stop_o
);
  import sws_pkg::*;

  sws_state_t st_r;
  sws_state_t st_nxt;
  logic       samp_tick;
  logic       time_tick;
  logic       det_en;
  logic       take_smp;
  logic       stamp_ev;
  logic       stamp_load;
  logic       bus_req;
  logic       bus_wr;
  logic       bus_rd;

  // low active select
  // Active level of a sample under the chosen polarity
  function automatic logic is_active(input logic lvl, input logic pol_low);
    is_active = pol_low ? ~lvl : lvl;
  endfunction

  // Byte-lane merge of a Wishbone write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    lane_merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  // Detection runs only while the pin is configured as input
  // input mode gate
  assign det_en = (st_r.cfg.stamp_pin_mode == `SWS_PIN_MODE_INPUT);

  sws_rate_div #(
    .DIV (SAMPLE_DIV)
  ) u_sample_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (det_en & st_r.cfg.stamp_input_switch_select),
    .tick_o (samp_tick)
  );

  sws_rate_div #(
    .DIV (TICK_DIV)
  ) u_time_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (1'b1),
    .tick_o (time_tick)
  );

  assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;
  assign bus_wr  = bus_req & wb_req_i.we;
  assign bus_rd  = bus_req & ~wb_req_i.we;

  assign take_smp = st_r.cfg.stamp_input_switch_select ? samp_tick : 1'b1;

  assign stamp_ev = det_en & take_smp & st_r.samp_valid
                  & ~is_active(st_r.samp_lvl, st_r.cfg.stamp_polarity_low)
                  & is_active(st_r.sync2, st_r.cfg.stamp_polarity_low);

  assign stamp_load = stamp_ev & (st_r.cfg.second_stamp_mode == `SWS_STAMP2_LAST_EVENT);

  always_comb begin
    st_nxt = st_r;

    // Pin crosses into the clock domain through two flops
    st_nxt.sync1 = stamp_pin_i;
    st_nxt.sync2 = st_r.sync1;

    // Stop follows pin stop mode off at once
    st_nxt.stop = st_r.stop & st_r.cfg.pin_stop_mode;

    if (!det_en) begin
      st_nxt.samp_valid = 1'b0;
      st_nxt.stop       = 1'b0;
    end else if (take_smp) begin
      st_nxt.samp_lvl   = st_r.sync2;
      st_nxt.samp_valid = 1'b1;
      st_nxt.stop = st_r.cfg.pin_stop_mode
                  & is_active(st_r.sync2, st_r.cfg.stamp_polarity_low);
    end

    // stop blocks time tick
    // Stop about to rise also holds the tick, so the stamp matches the frozen time
    if (time_tick && !st_r.stop && !st_nxt.stop) begin
      st_nxt.time_cnt = st_r.time_cnt + 32'h1;
    end

    if (stamp_load) begin
      st_nxt.stamp2 = st_r.time_cnt;
    end

    if (st_r.pulse_cnt != 8'h00) begin
      st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
    end
    if (stamp_load) begin
      st_nxt.pulse_cnt = `SWS_IRQ_PULSE_CYC;
    end

    // Bus writes; ack answers one cycle after the request
    st_nxt.ack = bus_req;
    if (bus_wr) begin
      unique case (wb_req_i.adr)
        `SWS_ADDR_CTRL: begin
          st_nxt.cfg = sws_cfg_t'(14'(lane_merge(32'(st_r.cfg), wb_req_i.dat,
                                                 wb_req_i.sel) & 32'h0000_37fb));
        end
        `SWS_ADDR_STATUS: begin
          if (wb_req_i.sel[0] && wb_req_i.dat[`SWS_STS_FLAG_BIT]) begin
            st_nxt.flag = 1'b0;
          end
        end
        `SWS_ADDR_MASK: begin
          if (wb_req_i.sel[0]) begin
            st_nxt.mask = wb_req_i.dat[0];
          end
        end
        `SWS_ADDR_TIME: begin
          st_nxt.time_cnt = lane_merge(st_r.time_cnt, wb_req_i.dat, wb_req_i.sel);
        end
        default: begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    // flag set
    if (stamp_load) begin
      st_nxt.flag = 1'b1;
    end

    // Reads; unmapped offsets answer zero
    st_nxt.dat = 32'h0;
    if (bus_rd) begin
      unique case (wb_req_i.adr)
        `SWS_ADDR_CTRL:   st_nxt.dat = 32'(st_r.cfg);
        `SWS_ADDR_STATUS: begin
          st_nxt.dat[`SWS_STS_FLAG_BIT]  = st_r.flag;
          st_nxt.dat[`SWS_STS_STOP_BIT]  = st_r.stop;
          st_nxt.dat[`SWS_STS_VALID_BIT] = st_r.samp_valid;
          st_nxt.dat[`SWS_STS_LEVEL_BIT] = st_r.samp_lvl;
        end
        `SWS_ADDR_MASK:   st_nxt.dat = {31'h0, st_r.mask};
        `SWS_ADDR_TIME:   st_nxt.dat = st_r.time_cnt;
        `SWS_ADDR_STAMP2: st_nxt.dat = st_r.stamp2;
        default:          st_nxt.dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.cfg  <= sws_cfg_t'(`SWS_CTRL_RESET);
      st_r.mask <= `SWS_MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign stop_o   = st_r.stop;
  assign irq_o    = st_r.flag & st_r.mask;

  // Output A only carries interrupts in its interrupt pin mode
  // enable gate
  assign irq_out_a_o = (st_r.cfg.irq_a_pin_mode == `SWS_IRQ_A_PIN_IRQ)
                     & st_r.cfg.stamp_irq_enable_a
                     & (st_r.cfg.irq_a_level_not_pulse ? st_r.flag
                                                       : (st_r.pulse_cnt != 8'h00));

  a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_invalid_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.cfg.stamp_pin_mode != `SWS_PIN_MODE_INPUT) |=> !st_r.samp_valid)
    else $error("sample valid while detection is off");

  a_event_sampled: assert property (@(posedge clk_i) disable iff (rst_i)
    stamp_ev |-> (take_smp && st_r.samp_valid && det_en))
    else $error("event without a valid sample");

  a_fall_event: assert property (@(posedge clk_i) disable iff (rst_i)
    (det_en && take_smp && st_r.samp_valid && st_r.cfg.stamp_polarity_low
     && st_r.samp_lvl && !st_r.sync2) |-> stamp_ev)
    else $error("high to low sample missed");

  a_stamp_loads: assert property (@(posedge clk_i) disable iff (rst_i)
    stamp_load |=> (st_r.flag && st_r.stamp2 == $past(st_r.time_cnt)))
    else $error("stamp not loaded with current time");

  a_stop_on_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (det_en && take_smp && st_r.cfg.pin_stop_mode && st_r.cfg.stamp_polarity_low
     && !st_r.sync2) |=> st_r.stop)
    else $error("stop not raised on low sample");

  a_release_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (det_en && take_smp && st_r.cfg.stamp_polarity_low && st_r.sync2) |=> !st_r.stop)
    else $error("stop not released on high sample");

  a_time_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.stop && !(bus_wr && wb_req_i.adr == `SWS_ADDR_TIME))
    |=> st_r.time_cnt == $past(st_r.time_cnt))
    else $error("time advanced while stopped");

  a_irq_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (stamp_load && st_r.cfg.stamp_irq_enable_a && !st_r.cfg.irq_a_level_not_pulse
     && st_r.cfg.irq_a_pin_mode == `SWS_IRQ_A_PIN_IRQ
     && !(bus_wr && wb_req_i.adr == `SWS_ADDR_CTRL))
    |=> irq_out_a_o [*8] ##1 !irq_out_a_o)
    else $error("interrupt pulse width wrong");

endmodule

// >>> tb/sws_switch_model.sv
`timescale 1ns/1ps
// Switch to ground; the pin pull-up holds the level high while the switch is open
module sws_switch_model (
  input  wire logic closed_i,
  output logic      pin_o
);
  // Never left floating, so no unknown reaches the sampler
  assign pin_o = closed_i ? 1'b0 : 1'b1;
endmodule

// >>> tb/test_switch_timestamp_stop_control.sv
`timescale 1ns/1ps
module test_switch_timestamp_stop_control;
  import sws_pkg::*;
  localparam int SD = 16;
  logic        clk_i;
  logic        rst_i;
  logic        closed;
  logic        pin;
  sws_wb_req_t req;
  logic        wb_ack_o;
  logic        irq_out_a_o;
  logic        irq_o;
  logic        stop_o;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic [31:0] t;
  logic [31:0] v;
  int          miscompares;
  int          checked;
  int          n;
  int          seed;

  sws_stamp_ctrl #(.SAMPLE_DIV(SD), .TICK_DIV(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .stamp_pin_i(pin), .irq_out_a_o(irq_out_a_o), .irq_o(irq_o), .stop_o(stop_o));
  sws_switch_model sw (.closed_i(closed), .pin_o(pin));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait: 0 ack, 1 interrupt A high, 2 stop released
  task wt(input int w, input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        miscompares++;
        stop_test;
      end
    end while (!(w == 0 ? wb_ack_o === 1'b1 : w == 1 ? irq_out_a_o === 1'b1 : stop_o === 1'b0));
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        miscompares++;
        stop_test;
      end
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
  endtask

  initial begin
    req = '0;
    closed = 1'b0;
    rst_i = 1'b1;
    seed = 32'hb2bf;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", q, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk("mask reset", q, 32'h0);
    wb(1'b1, 8'h00, 32'h0000001b);
    wb(1'b0, 8'h04, 32'h0);
    chk("status early", q, 32'h0);
    repeat (4 * SD) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk("status sampled", q, 32'h0000000c);
    wb(1'b1, 8'h00, 32'h0000257b);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h0000257b);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test setup done");
    @(posedge clk_i);
    closed <= 1'b1;
    wt(1, 3 * SD);
    chk("stop on", stop_o, 32'h1);
    n = 0;
    while (irq_out_a_o === 1'b1 && n < 20) begin
      n++;
      @(negedge clk_i);
    end
    chk("pulse width", n, 32'h8);
    wb(1'b0, 8'h04, 32'h0);
    chk("status event", q, 32'h00000007);
    wb(1'b0, 8'h0c, 32'h0);
    t = q;
    wb(1'b0, 8'h10, 32'h0);
    chk("stamp2", q, t);
    wb(1'b0, 8'h0c, 32'h0);
    chk("time frozen", q, t);
    v = $random(seed);
    wb(1'b1, 8'h0c, v);
    wb(1'b0, 8'h0c, 32'h0);
    chk("time set", q, v);
    wb(1'b1, 8'h10, ~v);
    wb(1'b0, 8'h10, 32'h0);
    chk("stamp2 ro", q, t);
    $display("test event done");
    chk("irq masked", irq_o, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    chk("irq level", irq_o, 32'h1);
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("status clr", q, 32'h00000006);
    chk("irq clr", irq_o, 32'h0);
    $display("test irq done");
    @(posedge clk_i);
    closed <= 1'b0;
    wt(2, 3 * SD);
    wb(1'b0, 8'h0c, 32'h0);
    t = q;
    repeat (20) @(posedge clk_i);
    wb(1'b0, 8'h0c, 32'h0);
    chk("time runs", q != t, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("no rise event", q, 32'h0000000c);
    $display("test release done");
    wb(1'b1, 8'h00, 32'h00002578);
    @(posedge clk_i);
    closed <= 1'b1;
    repeat (4 * SD) @(posedge clk_i);
    chk("pin off stop", stop_o, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk("pin off flag", q[0], 32'h0);
    $display("test pin mode done");
    stop_test;
  end
endmodule
